// ---- rtl/asrc_core.sv ----
// rtl: input buffer fifo and the stereo asynchronous sample rate converter
module asrc_fifo
    import asrc_pkg::*;
#(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    // drain side
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } asrc_fifo_s;

    asrc_fifo_s       q;
    asrc_fifo_s       d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign wr_ready = (q.cnt != (AW+1)'(DEPTH));
    assign rd_valid = (q.cnt != '0);
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;
    assign rd_data  = mem[q.rp];

    always_comb begin
        d = q;
        if (push) begin
            d.wp = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[q.wp] <= wr_data;
        end
    end
endmodule

module asrc_core
    import asrc_pkg::*;
#(
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // input sample port
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire asrc_stereo_s in_sample,
    // output sample port
    input  wire logic         out_strobe,
    output logic              out_valid,
    output asrc_stereo_s      out_sample,
    // write offset and mute register
    input  wire logic         gd_wr_en,
    input  wire logic [7:0]   gd_wr_data,
    output logic [7:0]        gd_rd_data,
    // rate error status
    output logic              fast_mode,
    output logic              slow_mode_entered
);
    if (BUF_DEPTH < 2) begin : g_bad_buf
        $error("input buffer depth must be at least 2");
    end

    typedef struct packed {
        asrc_state_e                st;
        logic [7:0]                 gd;
        logic [MUTE_W-1:0]          mute_gain;
        logic [RAM_AW-1:0]          wr_cnt;
        logic [RAM_AW-1:0]          snap_wr;
        logic [RAM_AW-1:0]          base_wr;
        logic [CNT_W-1:0]           since_in;
        logic [CNT_W-1:0]           since_out;
        logic [CNT_W-1:0]           since_tk;
        logic [CNT_W-1:0]           snap_in;
        logic [AVG_W-1:0]           avg_in;
        logic [AVG_W-1:0]           avg_out;
        logic                       fast;
        logic [SETTLE_CW-1:0]       settle_cnt;
        logic                       settle_pulse;
        logic [2:0]                 win_cnt;
        logic [NIN_W-1:0]           n_in;
        logic [NIN_W-1:0]           n_prev;
        logic                       ratio_dec;
        logic                       ratio_req;
        logic [PHASE_BITS:0]        step;
        logic [PHASE_BITS-1:0]      frac;
        logic [PHASE_BITS:0]        div_rem;
        logic [PHASE_BITS:0]        div_quo;
        logic [PHASE_BITS-1:0]      div_den;
        logic [4:0]                 div_cnt;
        logic                       div_ratio;
        logic                       out_pend;
        logic [RAM_AW-1:0]          rd_ptr;
        logic [ROM_PTR_W-1:0]       rom_ptr;
        logic signed [ACC_W-1:0]    acc_l;
        logic signed [ACC_W-1:0]    acc_r;
        asrc_stereo_s               out_s;
        logic                       out_v;
    } asrc_core_s;

    localparam logic signed [ACC_W-1:0] SAT_HI = ACC_W'((64'sd1 <<< (SAMPLE_W-1)) - 1);
    localparam logic signed [ACC_W-1:0] SAT_LO = -ACC_W'(64'sd1 <<< (SAMPLE_W-1));
    localparam logic [PHASE_BITS:0]     UNITY  = (PHASE_BITS+1)'(1 << PHASE_BITS);

    asrc_core_s                 q;
    asrc_core_s                 d;
    logic signed [SAMPLE_W-1:0] ram_l [RAM_DEPTH];
    logic signed [SAMPLE_W-1:0] ram_r [RAM_DEPTH];
    asrc_stereo_s               buf_data;
    logic                       buf_valid;
    logic                       drain_ready;
    logic                       pop;
    logic                       take;
    logic signed [COEF_W-1:0]   coef;
    logic signed [SAMPLE_W-1:0] mac_a;
    logic signed [ACC_W-1:0]    prod;
    logic [PHASE_BITS:0]        gain;
    logic signed [AVG_W+1:0]    err_in;
    logic signed [AVG_W+1:0]    err_out;

    // base kernel entry i of the stored subset, i in 0..64
    function automatic logic signed [COEF_W-1:0] coef_at(input logic [6:0] i);
        logic [6:0]  j;
        logic [12:0] p;
        j = 7'(TAPS) - i;
        p = 13'(i * j);
        return COEF_W'(13'(p * 13'(COEF_SCALE)));
    endfunction

    // linear interpolation between neighbouring stored entries
    function automatic logic signed [COEF_W-1:0] coef_interp(input logic [ROM_PTR_W-1:0] p);
        logic signed [COEF_W:0]    c0;
        logic signed [COEF_W:0]    c1;
        logic signed [COEF_W:0]    dl;
        logic signed [COEF_W+15:0] m;
        c0 = (COEF_W+1)'(coef_at({1'b0, p[ROM_PTR_W-1 -: 6]}));
        c1 = (COEF_W+1)'(coef_at(7'({1'b0, p[ROM_PTR_W-1 -: 6]}) + 7'd1));
        dl = c1 - c0;
        m  = dl * signed'({1'b0, p[PHASE_BITS-1 -: COEF_IFRAC]});
        return COEF_W'(c0 + (COEF_W+1)'(m >>> COEF_IFRAC));
    endfunction

    function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [ACC_W-1:0] a);
        logic signed [ACC_W-1:0] s;
        s = a >>> COEF_FRAC;
        if (s > SAT_HI) begin
            return SAMPLE_W'(SAT_HI);
        end else if (s < SAT_LO) begin
            return SAMPLE_W'(SAT_LO);
        end
        return SAMPLE_W'(s);
    endfunction

    // ratio gain in Q20 then mute gain in Q8
    function automatic logic signed [SAMPLE_W-1:0] scale(input logic signed [SAMPLE_W-1:0] s,
                                                        input logic [PHASE_BITS:0]      g,
                                                        input logic [MUTE_W-1:0]        m);
        logic signed [SAMPLE_W+PHASE_BITS+1:0] a;
        logic signed [SAMPLE_W+MUTE_W:0]       b;
        a = s * signed'({1'b0, g});
        b = SAMPLE_W'(a >>> PHASE_BITS) * signed'({1'b0, m});
        return SAMPLE_W'(b >>> MUTE_SHIFT);
    endfunction

    function automatic logic [AVG_W+1:0] mag(input logic signed [AVG_W+1:0] e);
        return (e < 0) ? (AVG_W+2)'(-e) : (AVG_W+2)'(e);
    endfunction

    asrc_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .wr_data  (in_sample),
        .rd_valid (buf_valid),
        .rd_ready (drain_ready),
        .rd_data  (buf_data)
    );

    // writes are held off while a start pointer is computed, so the snapshot stays coherent
    assign drain_ready = !(q.st inside {ST_DIV, ST_LOAD});
    assign pop         = buf_valid && drain_ready;
    assign take        = in_valid && in_ready;

    assign coef  = coef_interp(q.rom_ptr);
    assign mac_a = (q.st == ST_MAC_L) ? ram_l[q.rd_ptr] : ram_r[q.rd_ptr];
    assign prod  = ACC_W'(mac_a * coef);
    assign gain  = q.ratio_dec ? q.step : UNITY;

    assign err_in  = signed'({2'b00, q.since_tk, 4'h0}) - signed'({2'b00, q.avg_in});
    assign err_out = signed'({2'b00, q.since_out, 4'h0}) - signed'({2'b00, q.avg_out});

    assign gd_rd_data        = q.gd;
    assign fast_mode         = q.fast;
    assign slow_mode_entered = q.settle_pulse;
    assign out_valid         = q.out_v;
    assign out_sample        = q.out_s;

    always_comb begin
        logic [PHASE_BITS:0]     r2;
        logic [PHASE_BITS:0]     qn;
        logic [PHASE_BITS:0]     res;
        logic [ROM_PTR_W:0]      nxt;
        logic [PHASE_BITS-1:0]   den;
        logic [AVG_W+1:0]        thr;
        logic                    jump;
        logic                    calm;
        r2   = '0;
        qn   = '0;
        res  = '0;
        nxt  = '0;
        den  = '0;
        thr  = '0;
        jump = 1'b0;
        calm = 1'b0;
        d    = q;
        d.out_v        = 1'b0;
        d.settle_pulse = 1'b0;

        if (gd_wr_en) begin
            d.gd = gd_wr_data;
        end

        // soft mute ramp toward full or zero gain, one step per stored sample
        if (pop) begin
            if (q.gd[MUTE_BIT] && q.mute_gain != '0) begin
                d.mute_gain = q.mute_gain - MUTE_W'(MUTE_STEP);
            end else if (!q.gd[MUTE_BIT] && q.mute_gain != MUTE_W'(MUTE_FULL)) begin
                d.mute_gain = q.mute_gain + MUTE_W'(MUTE_STEP);
            end
            d.wr_cnt = q.wr_cnt + 1'b1;
            d.n_in   = (q.n_in == '1) ? q.n_in : q.n_in + 1'b1;
        end

        // servo: coarse period counts averaged, fast then slow time constant
        // input period timed on takes: drain stalls would jitter pops and block settling
        d.since_in  = (q.since_in == '1) ? q.since_in : q.since_in + 1'b1;
        d.since_tk  = (q.since_tk == '1) ? q.since_tk : q.since_tk + 1'b1;
        d.since_out = (q.since_out == '1) ? q.since_out : q.since_out + 1'b1;
        thr  = (AVG_W+2)'(q.avg_in >> JUMP_SHIFT);
        if (pop) begin
            d.since_in = CNT_W'(1);
        end
        if (take) begin
            d.since_tk = CNT_W'(1);
            d.avg_in   = q.avg_in + AVG_W'(err_in >>> (q.fast ? FAST_SHIFT : SLOW_SHIFT));
            jump = mag(err_in) > thr;
            calm = mag(err_in) < (AVG_W+2)'(SETTLE_THR);
        end
        if (out_strobe) begin
            d.since_out = CNT_W'(1);
            d.avg_out   = q.avg_out + AVG_W'(err_out >>> (q.fast ? FAST_SHIFT : SLOW_SHIFT));
            if (mag(err_out) > (AVG_W+2)'(q.avg_out >> JUMP_SHIFT)) begin
                jump = 1'b1;
            end
        end
        if (jump) begin
            d.fast       = 1'b1;
            d.settle_cnt = '0;
        end else if (q.fast && take) begin
            if (calm) begin
                d.settle_cnt = q.settle_cnt + 1'b1;
                if (q.settle_cnt == SETTLE_CW'(SETTLE_COUNT - 1)) begin
                    d.fast         = 1'b0;
                    d.settle_pulse = 1'b1;
                end
            end else begin
                d.settle_cnt = '0;
            end
        end

        // output instant: snapshot of input ramp, plus rate ratio window
        if (out_strobe) begin
            d.out_pend = 1'b1;
            d.snap_in  = q.since_in;
            d.snap_wr  = q.wr_cnt;
            d.win_cnt  = q.win_cnt + 1'b1;
            if (q.win_cnt == 3'(RATIO_WIN - 1)) begin
                d.n_in = NIN_W'(pop);
                if (q.n_in > NIN_W'(RATIO_WIN)) begin
                    if (!q.ratio_dec || q.n_in > q.n_prev + NIN_W'(RATIO_HYST) ||
                        q.n_prev > q.n_in + NIN_W'(RATIO_HYST)) begin
                        d.n_prev    = q.n_in;
                        d.ratio_req = 1'b1;
                    end
                end else begin
                    d.ratio_dec = 1'b0;
                    d.n_prev    = q.n_in;
                end
            end
        end

        case (q.st)
            ST_IDLE: begin
                if (q.out_pend) begin
                    den = (q.avg_in[AVG_W-1:AVG_FRAC] == '0) ? PHASE_BITS'(1)
                                                              : q.avg_in[AVG_W-1:AVG_FRAC];
                    d.div_den   = den;
                    d.div_rem   = (q.snap_in >= den) ? {1'b0, den - 1'b1} : {1'b0, q.snap_in};
                    d.div_quo   = '0;
                    d.div_cnt   = '0;
                    d.div_ratio = 1'b0;
                    d.base_wr   = q.snap_wr;
                    d.out_pend  = out_strobe;
                    d.st        = ST_DIV;
                end else if (q.ratio_req) begin
                    d.div_den   = PHASE_BITS'(q.n_prev);
                    d.div_rem   = (PHASE_BITS+1)'(RATIO_WIN);
                    d.div_quo   = '0;
                    d.div_cnt   = '0;
                    d.div_ratio = 1'b1;
                    d.ratio_req = 1'b0;
                    d.st        = ST_DIV;
                end
            end
            ST_DIV: begin
                r2 = {q.div_rem[PHASE_BITS-1:0], 1'b0};
                qn = {q.div_quo[PHASE_BITS-1:0], 1'b0};
                if (r2 >= {1'b0, q.div_den}) begin
                    r2 = r2 - {1'b0, q.div_den};
                    qn[0] = 1'b1;
                end
                d.div_rem = r2;
                d.div_quo = qn;
                d.div_cnt = q.div_cnt + 1'b1;
                if (q.div_cnt == 5'(DIV_STEPS - 1)) begin
                    res = (qn + 1'b1) >> 1;
                    if (q.div_ratio) begin
                        d.step      = res;
                        d.ratio_dec = 1'b1;
                        d.st        = ST_IDLE;
                    end else begin
                        d.frac = res[PHASE_BITS] ? '1 : res[PHASE_BITS-1:0];
                        d.st   = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                // newest usable sample sits MIN_OFFSET plus the write offset behind the last written word
                d.rd_ptr = q.base_wr - RAM_AW'(1) - RAM_AW'(MIN_OFFSET)
                         - RAM_AW'(q.gd[GD_LSB +: GD_W]);
                d.rom_ptr = q.ratio_dec ?
                            ROM_PTR_W'(({20'h0, q.frac} * {20'h0, q.step}) >> PHASE_BITS) :
                            ROM_PTR_W'(q.frac);
                d.acc_l = '0;
                d.acc_r = '0;
                d.st    = ST_MAC_L;
            end
            ST_MAC_L: begin
                d.acc_l = q.acc_l + prod;
                d.st    = ST_MAC_R;
            end
            ST_MAC_R: begin
                d.acc_r  = q.acc_r + prod;
                d.rd_ptr = q.rd_ptr - 1'b1;
                nxt = {1'b0, q.rom_ptr} + (ROM_PTR_W+1)'(gain);
                d.rom_ptr = nxt[ROM_PTR_W-1:0];
                d.st      = nxt[ROM_PTR_W] ? ST_DONE : ST_MAC_L;
            end
            ST_DONE: begin
                d.out_s.left  = sat(q.acc_l);
                d.out_s.right = sat(q.acc_r);
                d.out_v       = 1'b1;
                d.st          = ST_IDLE;
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q           <= '0;
            q.st        <= ST_IDLE;
            q.gd        <= REG_RESET;
            q.mute_gain <= MUTE_W'(MUTE_FULL);
            q.fast      <= 1'b1;
            q.step      <= UNITY;
        end else begin
            q <= d;
        end
    end

    // sample RAM, 512 words a channel, written with scaled and ramped input
    always_ff @(posedge clk) begin
        if (pop) begin
            ram_l[q.wr_cnt] <= scale(buf_data.left, gain, q.mute_gain);
            ram_r[q.wr_cnt] <= scale(buf_data.right, gain, q.mute_gain);
        end
    end
endmodule

// ---- shared/asrc_pkg.sv ----
// package: constants and types of the stereo asynchronous sample rate converter
package asrc_pkg;
    localparam int SAMPLE_W        = 24;
    localparam int TAPS            = 64;
    localparam int PHASE_BITS      = 20;
    localparam int ROM_PTR_W       = 26;
    localparam int RAM_DEPTH       = 512;
    localparam int RAM_AW          = 9;
    localparam int MIN_OFFSET      = 16;
    localparam int GD_LSB          = 0;
    localparam int GD_W            = 7;
    localparam int MUTE_BIT        = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int COEF_W          = 18;
    localparam int COEF_FRAC       = 17;
    localparam int COEF_SCALE      = 3;
    localparam int COEF_IFRAC      = 14;
    localparam int ACC_W           = 48;
    localparam int MUTE_W          = 9;
    localparam int MUTE_SHIFT      = 8;
    localparam int MUTE_FULL       = 256;
    localparam int MUTE_STEP       = 1;
    localparam int CNT_W           = 20;
    localparam int AVG_W           = 24;
    localparam int AVG_FRAC        = 4;
    localparam int FAST_SHIFT      = 2;
    localparam int SLOW_SHIFT      = 6;
    localparam int JUMP_SHIFT      = 3;
    localparam int SETTLE_THR      = 16;
    localparam int SETTLE_COUNT    = 16;
    localparam int SETTLE_CW       = 5;
    localparam int RATIO_WIN       = 8;
    localparam int RATIO_HYST      = 2;
    localparam int NIN_W           = 8;
    localparam int DIV_STEPS       = 21;
    localparam int FIFO_DEPTH      = 8;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] left;
        logic signed [SAMPLE_W-1:0] right;
    } asrc_stereo_s;

    localparam int FIFO_W = $bits(asrc_stereo_s);

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_DIV   = 6'h02,
        ST_LOAD  = 6'h04,
        ST_MAC_L = 6'h08,
        ST_MAC_R = 6'h10,
        ST_DONE  = 6'h20
    } asrc_state_e;
endpackage

// ---- test/asrc_core_sva.sv ----
// checker: port-level assertions for the sample rate converter
module asrc_core_sva
    import asrc_pkg::*;
#(
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic         clk,
    input wire logic         sys_rst,
    // watched ports
    input wire logic         in_valid,
    input wire logic         in_ready,
    input wire asrc_stereo_s in_sample,
    input wire logic         out_strobe,
    input wire logic         out_valid,
    input wire asrc_stereo_s out_sample,
    input wire logic         gd_wr_en,
    input wire logic [7:0]   gd_wr_data,
    input wire logic [7:0]   gd_rd_data,
    input wire logic         fast_mode,
    input wire logic         slow_mode_entered
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] takes_q;
    // counts only takes of the current fast spell
    always_ff @(posedge clk) begin
        if (sys_rst || !fast_mode) takes_q <= 8'h00;
        else if (in_valid && in_ready && takes_q != 8'hff) takes_q <= takes_q + 8'h01;
    end
    sequence fast_to_slow;
        $past(fast_mode) && !fast_mode;
    endsequence
    chk_reg_readback: assert property (gd_wr_en |=> gd_rd_data == $past(gd_wr_data))
        else $error("offset register readback wrong");
    chk_reg_holds: assert property (!gd_wr_en |=> $stable(gd_rd_data))
        else $error("offset register changed without write");
    chk_slow_pulse: assert property (slow_mode_entered |-> fast_to_slow)
        else $error("slow pulse without fast to slow change");
    chk_fall_flags: assert property (fast_to_slow |-> slow_mode_entered)
        else $error("fast to slow change without pulse");
    chk_valid_pulse: assert property (out_valid |=> !out_valid [*8])
        else $error("results closer than one convolution");
    chk_sample_held: assert property (!out_valid |-> $stable(out_sample))
        else $error("output sample moved without valid");
    chk_reset_state: assert property ($fell(sys_rst) |-> fast_mode && in_ready
        && !out_valid && gd_rd_data == REG_RESET) else $error("bad state after reset");
    chk_settle_min: assert property (slow_mode_entered |-> takes_q >= 8'h10)
        else $error("fast mode left too early");
    chk_strobe_answer: assert property (out_strobe |-> ##[1:1000] out_valid)
        else $error("no result after output strobe");
endmodule
bind asrc_core asrc_core_sva #(.BUF_DEPTH(BUF_DEPTH)) sva (.clk(clk), .sys_rst(sys_rst),
    .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample),
    .out_strobe(out_strobe), .out_valid(out_valid), .out_sample(out_sample),
    .gd_wr_en(gd_wr_en), .gd_wr_data(gd_wr_data), .gd_rd_data(gd_rd_data),
    .fast_mode(fast_mode), .slow_mode_entered(slow_mode_entered));

// ---- test/asrc_port_model.sv ----
// partner: on-chip audio source and sink sample ports
module asrc_port_model
    import asrc_pkg::*;
#(
    parameter logic signed [SAMPLE_W-1:0] LEVEL = 24'sh100000
) (
    // clock, reset and pacing
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        run,
    input  wire logic [15:0] in_per,
    input  wire logic [15:0] out_per,
    // converter side
    output logic             in_valid,
    output asrc_stereo_s     in_sample,
    input  wire logic        in_ready,
    output logic             out_strobe,
    output int               taken,
    output logic             refused
);
    logic took_q = 1'b0;
    int   in_cnt = 0;
    int   out_cnt = 0;
    initial begin
        in_valid = 1'b0;
        out_strobe = 1'b0;
        in_sample = '0;
        taken = 0;
        refused = 1'b0;
    end
    always @(posedge clk) took_q <= in_valid && in_ready;
    // a released sample bus shows the inverse, never a stale copy
    always @(negedge clk) begin
        if (sys_rst || !run) begin
            in_valid = 1'b0;
            out_strobe = 1'b0;
            in_cnt = 0;
            out_cnt = 0;
        end else begin
            out_cnt = out_cnt + 1;
            out_strobe = (out_cnt >= int'(out_per));
            if (out_strobe) out_cnt = 0;
            in_cnt = in_cnt + 1;
            // one edge passes between offers, so valid never drops and rises at once
            if (took_q) begin
                taken = taken + 1;
                in_valid = 1'b0;
                in_sample = ~in_sample;
            end else if (!in_valid && in_cnt >= int'(in_per)) begin
                in_valid = 1'b1;
                in_sample = '{LEVEL, -LEVEL};
                in_cnt = 0;
            end
            refused = refused | (in_valid & ~in_ready);
        end
    end
endmodule

// ---- test/async_sample_rate_converter_bench.sv ----
// bench: register, stream, burst and mute scenarios for the converter
module async_sample_rate_converter_bench;
    import asrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic signed [23:0] LVL = 24'sh100000;
    logic clk = 1'b0, sys_rst = 1'b1, run = 1'b0, gd_wr_en = 1'b0;
    logic [7:0] gd_wr_data = 8'h00, gd_rd_data;
    logic [7:0] regv [4] = '{8'h85, 8'h7f, 8'h80, 8'h00};
    logic [15:0] in_per = 16'h00c8, out_per = 16'h00aa;
    logic in_valid, in_ready, out_strobe, out_valid, fast_mode, slow_mode_entered, refused;
    asrc_stereo_s in_sample, out_sample, last_out;
    int taken, mismatches = 0, checks_done = 0, cycles = 0, n_slow = 0, mark, slow_before;
    always #20 clk = ~clk;
    asrc_core #(.BUF_DEPTH(FIFO_DEPTH)) dut (.clk(clk), .sys_rst(sys_rst),
        .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample),
        .out_strobe(out_strobe), .out_valid(out_valid), .out_sample(out_sample),
        .gd_wr_en(gd_wr_en), .gd_wr_data(gd_wr_data), .gd_rd_data(gd_rd_data),
        .fast_mode(fast_mode), .slow_mode_entered(slow_mode_entered));
    asrc_port_model #(.LEVEL(LVL)) peer (.clk(clk), .sys_rst(sys_rst), .run(run),
        .in_per(in_per), .out_per(out_per), .in_valid(in_valid), .in_sample(in_sample),
        .in_ready(in_ready), .out_strobe(out_strobe), .taken(taken), .refused(refused));
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (out_valid) last_out <= out_sample;
        if (slow_mode_entered) n_slow <= n_slow + 1;
        if (cycles == 100000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] v);
        @(negedge clk);
        gd_wr_en = 1'b1;
        gd_wr_data = v;
        @(negedge clk);
        gd_wr_en = 1'b0;
        check("offset register", {40'h0, v}, {40'h0, gd_rd_data});
    endtask
    task automatic inputs(input int n);
        mark = taken + n;
        while (taken < mark) @(negedge clk);
    endtask
    // lim is an absolute bound; a mute check passes 786432, three quarters of LVL
    task automatic level_check(input string what, input int lim, input logic mute);
        int l, r;
        l = last_out.left;
        r = last_out.right;
        if (mute) check(what, 48'h1, {47'h0, (l < lim) && (-r < lim)});
        else check(what, 48'h1, {47'h0, (l - LVL < lim) && (LVL - l < lim) && (l + r < lim)
            && (-l - r < lim)});
    endtask
    task automatic give_verdict();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        check("reset state", 48'h6, {37'h0, gd_rd_data, fast_mode, in_ready, out_valid});
        foreach (regv[i]) reg_write(regv[i]);
        run = 1'b1;
        // burst right after a strobe, while the drain is stalled
        @(posedge out_strobe);
        in_per = 16'h0001;
        repeat (30) @(negedge clk);
        in_per = 16'h00c8;
        check("fifo refusal", 48'h1, {47'h0, refused});
        repeat (40) @(negedge clk);
        check("fifo drained", 48'h1, {47'h0, in_ready});
        inputs(110);
        check("fast mode", 48'h0, {47'h0, fast_mode});
        check("slow entries", 48'h1, {16'h0, 32'(n_slow)});
        level_check("upsampled level", 32768, 1'b0);
        slow_before = n_slow;
        in_per = 16'h00a0;
        out_per = 16'h0140;
        inputs(200);
        check("resettled", 48'h1, {47'h0, (n_slow > slow_before) && !fast_mode});
        level_check("decimated level", 32768, 1'b0);
        reg_write(8'h80);
        inputs(180);
        level_check("muted level", 786432, 1'b1);
        give_verdict();
    end
endmodule
